// ===== verilog/hall_commutation_consts.vh
// Functional notes
// - event on any hall input transition
// - capture speed timer, clear it next cycle
// - sample hall pattern, select step
// - clockwise table pairs per hall state
// - counterclockwise table pairs per hall state
// - exactly two phases driven each step
// - one step advance per hall transition
// - step tables loadable, not fixed
// - separate tables chosen by direction input
// - gate output k drives switch k
// - mask passes duty, else override level; all gates low after an invalid position
// - three duties shared by output pairs
`ifndef HALL_COMMUTATION_CONSTS_VH
`define HALL_COMMUTATION_CONSTS_VH
`define TIMER_WIDTH 16
`define DUTY_WIDTH 8
`define GATE_COUNT 6
`define TIMER_RESET 16'h0000
`define GATE_RESET 6'h00
// clockwise masks indexed by hall state {a,b,c}
`define CW_000 6'h06
`define CW_001 6'h12
`define CW_011 6'h18
`define CW_100 6'h24
`define CW_110 6'h21
`define CW_111 6'h09
// counterclockwise masks
`define CCW_000 6'h09
`define CCW_001 6'h21
`define CCW_011 6'h24
`define CCW_100 6'h18
`define CCW_110 6'h12
`define CCW_111 6'h06
`endif

// ===== verilog/hall_commutation_decoder.v
`timescale 1ns/100ps
`default_nettype none
`include "hall_commutation_consts.vh"
module hall_commutation_decoder #(
    parameter TW = `TIMER_WIDTH,
    parameter DW = `DUTY_WIDTH
) (
    input wire clk_in,
    input wire rstn_in,
    input wire hall_capture_in_a,
    input wire hall_capture_in_b,
    input wire hall_capture_in_c,
    input wire dir_ccw_in,
    input wire table_load_in,
    input wire table_dir_in,
    input wire [2:0] table_index_in,
    input wire [5:0] table_data_in,
    input wire [DW-1:0] duty_0_in,
    input wire [DW-1:0] duty_1_in,
    input wire [DW-1:0] duty_2_in,
    input wire [5:0] override_state_bits_in,
    output reg [5:0] gate_out,
    output reg hall_event_out,
    output reg invalid_pos_out,
    output reg [TW-1:0] speed_capture_out,
    output reg [2:0] hall_state_out,
    output reg [5:0] channel_pass_mask_out
);

////////////////////////////////////////////////////////////////////////////////
// hall pins are asynchronous: two flops before any use
reg [2:0] hall_meta_r;
reg [2:0] hall_sync_r;
reg [2:0] hall_prev_r;
wire hall_change = (hall_sync_r != hall_prev_r);

always @(posedge clk_in) begin
    if (!rstn_in) begin
        hall_meta_r <= 3'h0;
        hall_sync_r <= 3'h0;
        hall_prev_r <= 3'h0;
    end else begin
        hall_meta_r <= {hall_capture_in_a, hall_capture_in_b, hall_capture_in_c};
        hall_sync_r <= hall_meta_r;
        hall_prev_r <= hall_sync_r;
    end
end

////////////////////////////////////////////////////////////////////////////////
// speed timer: captured on the change, cleared on the cycle after
reg [TW-1:0] speed_capture_timer_r;
reg clear_pend_r;

always @(posedge clk_in) begin
    if (!rstn_in) begin
        speed_capture_timer_r <= `TIMER_RESET;
        clear_pend_r <= 1'b0;
        speed_capture_out <= `TIMER_RESET;
        hall_event_out <= 1'b0;
    end else begin
        hall_event_out <= hall_change;
        clear_pend_r <= hall_change;
        if (hall_change)
            speed_capture_out <= speed_capture_timer_r;
        if (clear_pend_r)
            speed_capture_timer_r <= `TIMER_RESET;
        else if (speed_capture_timer_r != {TW{1'b1}})
            speed_capture_timer_r <= speed_capture_timer_r + 1'b1; // saturates on stall
    end
end

////////////////////////////////////////////////////////////////////////////////
// loadable step tables, one per direction; defaults are 60-degree placement
reg [5:0] cw_tab_r [0:7];
reg [5:0] ccw_tab_r [0:7];

function [5:0] cw_default;
    input [2:0] s;
    begin
        case (s)
            3'h0: cw_default = `CW_000;
            3'h1: cw_default = `CW_001;
            3'h3: cw_default = `CW_011;
            3'h4: cw_default = `CW_100;
            3'h6: cw_default = `CW_110;
            3'h7: cw_default = `CW_111;
            default: cw_default = `GATE_RESET;
        endcase
    end
endfunction

function [5:0] ccw_default;
    input [2:0] s;
    begin
        case (s)
            3'h0: ccw_default = `CCW_000;
            3'h1: ccw_default = `CCW_001;
            3'h3: ccw_default = `CCW_011;
            3'h4: ccw_default = `CCW_100;
            3'h6: ccw_default = `CCW_110;
            3'h7: ccw_default = `CCW_111;
            default: ccw_default = `GATE_RESET;
        endcase
    end
endfunction

// a loaded entry counts as valid only with one high and one low switch
function valid_step;
    input [5:0] m;
    begin
        valid_step = (m == 6'h03) ? 1'b0 : (m == 6'h0C) ? 1'b0 : (m == 6'h30) ? 1'b0 :
            ((m[0] + m[2] + m[4]) == 2'd1) && ((m[1] + m[3] + m[5]) == 2'd1);
    end
endfunction

genvar gi;
generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : tab_g
        localparam [2:0] ENTRY = gi;
        always @(posedge clk_in) begin
            if (!rstn_in) begin
                cw_tab_r[gi] <= cw_default(ENTRY);
                ccw_tab_r[gi] <= ccw_default(ENTRY);
            end else if (table_load_in && table_index_in == ENTRY) begin
                if (table_dir_in)
                    ccw_tab_r[gi] <= table_data_in;
                else
                    cw_tab_r[gi] <= table_data_in;
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// step select: one new step per detected transition
wire [5:0] step_sel = dir_ccw_in ? ccw_tab_r[hall_sync_r] : cw_tab_r[hall_sync_r];

always @(posedge clk_in) begin
    if (!rstn_in) begin
        hall_state_out <= 3'h0;
        channel_pass_mask_out <= `GATE_RESET;
        invalid_pos_out <= 1'b0;
    end else begin
        invalid_pos_out <= 1'b0;
        if (hall_change) begin
            hall_state_out <= hall_sync_r;
            if (valid_step(step_sel)) begin
                channel_pass_mask_out <= step_sel;
            end else begin
                channel_pass_mask_out <= `GATE_RESET;
                invalid_pos_out <= 1'b1;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// duty ramp: free running counter compared against each pair's duty
reg [DW-1:0] ramp_r;
wire [2:0] duty_on = {ramp_r < duty_2_in, ramp_r < duty_1_in, ramp_r < duty_0_in};
reg invalid_hold_r;

always @(posedge clk_in) begin
    if (!rstn_in) begin
        ramp_r <= {DW{1'b0}};
        invalid_hold_r <= 1'b0;
    end else begin
        ramp_r <= ramp_r + 1'b1;
        if (hall_change)
            invalid_hold_r <= !valid_step(step_sel);
    end
end

generate
    for (gi = 0; gi < `GATE_COUNT; gi = gi + 1) begin : gate_g
        always @(posedge clk_in) begin
            if (!rstn_in)
                gate_out[gi] <= 1'b0;
            else if (invalid_hold_r)
                gate_out[gi] <= 1'b0;
            else if (channel_pass_mask_out[gi])
                gate_out[gi] <= duty_on[gi/2];
            else
                gate_out[gi] <= override_state_bits_in[gi];
        end
    end
endgenerate

endmodule
`default_nettype wire

// ===== tb/hall_commutation_chk.sv
`timescale 1ns/100ps
`default_nettype none
module hall_commutation_chk #(parameter TW = 16) (
    input wire clk_in,
    input wire rstn_in,
    input wire [5:0] override_state_bits_in,
    input wire [5:0] gate_out,
    input wire hall_event_out,
    input wire invalid_pos_out,
    input wire [TW-1:0] speed_capture_out,
    input wire [2:0] hall_state_out,
    input wire [5:0] channel_pass_mask_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    evt_pulse_a: assert property (hall_event_out |=> !hall_event_out) else $error("long event");
    evt_change_a: assert property (hall_event_out |-> hall_state_out != $past(hall_state_out))
        else $error("event without change");
    state_hold_a: assert property (!hall_event_out |-> $stable(hall_state_out)) else $error("state moved");
    step_hold_a: assert property (!hall_event_out |-> $stable(channel_pass_mask_out)) else $error("mask moved");
    cap_hold_a: assert property (!hall_event_out |-> $stable(speed_capture_out)) else $error("capture moved");
    step_valid_a: assert property (hall_event_out && !invalid_pos_out |-> channel_pass_mask_out != 6'h00)
        else $error("empty step");
    two_phase_a: assert property (channel_pass_mask_out != 6'h00 |-> $countones(channel_pass_mask_out) == 2 &&
        (channel_pass_mask_out & 6'h15) != 6'h00 && (channel_pass_mask_out & 6'h2A) != 6'h00) else $error("bad pair");
    bad_pos_a: assert property (invalid_pos_out |-> channel_pass_mask_out == 6'h00 ##1 gate_out == 6'h00)
        else $error("invalid not blanked");
    ovr_pass_a: assert property ($past(channel_pass_mask_out) != 6'h00 |->
        ((gate_out ^ $past(override_state_bits_in)) & ~$past(channel_pass_mask_out)) == 6'h00) else $error("override");
endmodule
bind hall_commutation_decoder hall_commutation_chk #(.TW(TW)) hall_commutation_chk_inst (.clk_in(clk_in),
    .rstn_in(rstn_in), .override_state_bits_in(override_state_bits_in), .gate_out(gate_out),
    .hall_event_out(hall_event_out), .invalid_pos_out(invalid_pos_out), .speed_capture_out(speed_capture_out),
    .hall_state_out(hall_state_out), .channel_pass_mask_out(channel_pass_mask_out));
`default_nettype wire

// ===== tb/hall_sensor_model.sv
`timescale 1ns/100ps
`default_nettype none
module hall_sensor_model (
    input wire clk_in,
    input wire adv_in,
    input wire ccw_in,
    input wire bad_in,
    output wire [2:0] hall_out
);
    // clockwise order from index 0: 000 100 110 111 011 001
    localparam [17:0] SEQ = 18'h0BFA0;
    reg [2:0] idx_r = 3'h0;
    always @(posedge clk_in) begin
        if (adv_in)
            idx_r <= ccw_in ? (idx_r == 3'h0 ? 3'h5 : idx_r - 3'h1) : (idx_r == 3'h5 ? 3'h0 : idx_r + 3'h1);
    end
    // forced pattern sits in neither table
    assign hall_out = bad_in ? 3'h2 : SEQ[idx_r*3 +: 3];
endmodule
`default_nettype wire

// ===== tb/hall_commutation_decoder_tb.sv
`timescale 1ns/100ps
`default_nettype none
module hall_commutation_decoder_tb;
reg clk_in = 0, rstn_in = 0, dir = 0, adv = 0, bad = 0, tl = 0;
reg [2:0] ti = 3'h0;
reg [5:0] td = 6'h00, ovr = 6'h00;
wire ev, inv;
wire [2:0] h, hs;
wire [5:0] g, m;
wire [15:0] cap;
integer miscompares = 0, cmp_count = 0, i, c0 = 0, c5 = 0, t1;
reg [8:0] rows [0:11] = '{9'h124, 9'h1A1, 9'h1C9, 9'h0D8, 9'h052, 9'h006,
    9'h061, 9'h0E4, 9'h1C6, 9'h192, 9'h118, 9'h009};
hall_sensor_model hall_sensor_model_inst (.clk_in(clk_in), .adv_in(adv), .ccw_in(dir), .bad_in(bad), .hall_out(h));
hall_commutation_decoder hall_commutation_decoder_inst (.clk_in(clk_in), .rstn_in(rstn_in),
    .hall_capture_in_a(h[2]), .hall_capture_in_b(h[1]), .hall_capture_in_c(h[0]), .dir_ccw_in(dir),
    .table_load_in(tl), .table_dir_in(dir), .table_index_in(ti), .table_data_in(td), .duty_0_in(8'h80),
    .duty_1_in(8'h20), .duty_2_in(8'h40), .override_state_bits_in(ovr), .gate_out(g), .hall_event_out(ev),
    .invalid_pos_out(inv), .speed_capture_out(cap), .hall_state_out(hs), .channel_pass_mask_out(m));
initial begin
    forever #5 clk_in = ~clk_in;
end
task chk(input [15:0] s, input [15:0] e);
begin
    cmp_count = cmp_count + 1;
    if (s !== e) begin
        miscompares = miscompares + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
end
endtask
task tally_and_finish;
begin
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
end
endtask
// waits d cycles, moves the sensors one step, then waits for the event
task stp(input integer d);
    integer k;
begin
    repeat (d) @(posedge clk_in);
    #1 adv = 1;
    @(posedge clk_in);
    #1 adv = 0;
    for (k = 0; k < 20 && ev !== 1'b1; k = k + 1) begin
        @(posedge clk_in);
        #1;
    end
    if (k == 20) miscompares = miscompares + 1;
end
endtask
initial begin
    repeat (6) @(posedge clk_in);
    #1 chk({g, m}, 12'h000);
    rstn_in = 1;
    for (i = 0; i < 12; i = i + 1) begin
        dir = (i >= 6);
        stp(3);
        chk({hs, m}, rows[i]);
    end
    dir = 0;
    ti = 3'h4;
    td = 6'h06;
    tl = 1;
    @(posedge clk_in);
    #1 tl = 0;
    stp(20);
    chk(m, 6'h06);
    t1 = cap;
    stp(30);
    chk(cap - t1[15:0], 16'h0009);
    repeat (2) @(posedge clk_in);
    for (i = 0; i < 256; i = i + 1) begin
        @(posedge clk_in);
        #1 c0 = c0 + g[0];
        c5 = c5 + g[5];
    end
    chk(c0, 16'h0080);
    chk(c5, 16'h0040);
    chk(g & ~m, 6'h00);
    ovr = 6'h3F;
    repeat (2) @(posedge clk_in);
    #1 chk(g & 6'h1E, 6'h1E);
    bad = 1;
    stp(2);
    chk({inv, m}, 7'h40);
    @(posedge clk_in);
    #1 chk(g, 6'h00);
    tally_and_finish;
end
initial begin
    // whole run is under a thousand cycles
    #50000 miscompares = miscompares + 1;
    tally_and_finish;
end
endmodule
`default_nettype wire
